// [disc_tag_pkg.sv]
// Constants, types and state layouts for the drive-side tag decoder
// Behaviour
// (RULE1) Tags are decoded only while the drive is selected.
// (RULE2) A cylinder-select tag starts a seek to the loaded cylinder.
// (RULE3) Without extension, bus-out bits 0 to 9 load cylinder address weights 2^0..2^9.
// (RULE4) Low-tag extension also loads cylinder bit 10 from the current-sector tag line.
// (RULE5) A seek beyond the maximum legal cylinder raises seek error; unextended limit 1023.
// (RULE6) The status word is driven on bus-in while cylinder-select is active.
// (RULE7) With head-tag extension the controller sends the high-cylinder tag first.
// (RULE8) Ready means speed reached, first seek succeeded and no fault.
// (RULE9) On-cylinder is high on track and drops when the positioner drifts off.
// (RULE10) Seek error is raised when a seek takes too long.
// (RULE11) Seek error is also raised when the positioner leaves the recording area.
// (RULE12) A return-to-track-zero command clears a pending seek error.
// (RULE13) Fault is high while any of the seven fault conditions holds.
// (RULE14) Maintenance tag: bus-out 1:0 pick the reply; bit 7 flags valid or busy.
// (RULE15) Current-sector tag returns the sector count; sector and type tags off with low-tag extension.
package disc_tag_pkg;

  // ------------------------------------------------------------
  // Widths and bit positions
  // ------------------------------------------------------------
  localparam int BUS_OUT_W = 11;
  localparam int BUS_IN_W = 8;
  localparam int CYL_W = 12;
  localparam int LOW_CYL_W = 10;
  localparam int FAULT_W = 7;
  localparam int PIN_W = 7 + BUS_OUT_W;
  localparam int CYL_BIT10 = 10;
  localparam int CYL_BIT11 = 11;
  localparam int HI_CYL_BIT10_LINE = 7;
  localparam int HI_CYL_BIT11_LINE = 8;
  localparam int RTZ_LINE = 6;
  localparam int ST_READY = 0;
  localparam int ST_ON_TRACK = 1;
  localparam int ST_SEEK_ERR = 2;
  localparam int ST_FAULT = 3;
  localparam int MAINT_FLAG = 7;

  // ------------------------------------------------------------
  // Cylinder limits and maintenance request codes
  // ------------------------------------------------------------
  localparam logic [CYL_W-1:0] MAX_CYL_LARGE = 12'h0_662;
  localparam logic [CYL_W-1:0] MAX_CYL_SMALL = 12'h0_564;
  localparam logic [CYL_W-1:0] MAX_CYL_UNEXT = 12'h0_3FF;
  localparam logic [1:0] REQ_FAULT = 2'h0;
  localparam logic [1:0] REQ_OPER = 2'h1;
  localparam logic [1:0] REQ_UNIT = 2'h2;
  localparam logic [1:0] REQ_DIAG = 2'h3;

  // ------------------------------------------------------------
  // Timing: seek time limit in microseconds, clock in MHz
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned SEEK_LIMIT_US = 100_000;
  localparam int unsigned SEEK_LIMIT_CYC = SEEK_LIMIT_US * CLK_MHZ;

  // ------------------------------------------------------------
  // State types
  // ------------------------------------------------------------
  typedef enum logic {SEEK_IDLE, SEEK_BUSY} seek_state_type;

  typedef struct packed {
    seek_state_type st;
    logic [CYL_W-1:0] cyl;
    logic [1:0] hi_cyl;
    logic tag1_d;
    logic rtz_d;
    logic tag5_d;
    logic seek_err;
    logic first_ok;
    logic seek_start;
    logic return_to_track_zero_cmd;
    logic diag;
    logic ready;
    logic on_cyl;
    logic [BUS_IN_W-1:0] bus_in;
  } drive_state_type;

endpackage

// [pin_filter.sv]
// Three-flop pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_filter #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Pins and filtered levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } filt_type;

  filt_type q_ff;
  filt_type nxt_q;

  // Stage one feeds only stage two; the agreement test looks at two and three
  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = pin_i;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (q_ff.s2[i] == q_ff.s3[i]) begin
        nxt_q.lvl[i] = q_ff.s3[i];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign level_o = q_ff.lvl;

endmodule

// [seek_timer.sv]
// Watchdog that flags a seek which runs longer than its allowed time
`timescale 1ns/100ps
module seek_timer #(
  parameter int unsigned LIMIT = 4,
  parameter int W = $clog2(LIMIT + 1)
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Run and timeout
  input wire logic run_i,
  output logic expired_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic expired;
  } timer_type;

  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  timer_type q_ff;
  timer_type nxt_q;

  // Count only while a seek runs; restart from zero for every seek
  always_comb begin
    nxt_q = q_ff;
    if (!run_i) begin
      nxt_q = '0;
    end else if (q_ff.cnt == LAST) begin
      nxt_q.expired = 1'b1;
    end else begin
      nxt_q.cnt = q_ff.cnt + W'(1);
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign expired_o = q_ff.expired;

endmodule

// [disc_tag_bus_seek_status_port.sv]
// Drive-side tag decoder: cylinder select, seek start, status and maintenance replies
`timescale 1ns/100ps
module disc_tag_bus_seek_status_port
  import disc_tag_pkg::*;
#(
  parameter bit LOW_TAG_EXT = 1'b0,
  parameter bit HEAD_TAG_EXT = 1'b0,
  parameter logic [CYL_W-1:0] MAX_CYL = MAX_CYL_LARGE,
  parameter int unsigned SEEK_LIMIT_CYCLES = SEEK_LIMIT_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Cable pins from the controller
  input wire logic select_i,
  input wire logic tag1_i,
  input wire logic tag2_i,
  input wire logic tag3_i,
  input wire logic tag4_i,
  input wire logic tag5_i,
  input wire logic tag6_i,
  input wire logic [BUS_OUT_W-1:0] bus_out_i,
  // Drive conditions from servo and motor logic
  input wire logic speed_ok_i,
  input wire logic on_track_i,
  input wire logic off_recording_i,
  input wire logic seek_done_i,
  input wire logic [FAULT_W-1:0] fault_bits_i,
  // Maintenance and sector data
  input wire logic [FAULT_W-1:0] oper_status_i,
  input wire logic [FAULT_W-1:0] unit_code_i,
  input wire logic diag_busy_i,
  input wire logic [BUS_IN_W-1:0] sector_count_i,
  input wire logic [BUS_IN_W-1:0] device_type_i,
  // Cable bus-in lines
  output logic [BUS_IN_W-1:0] bus_in_o,
  // Positioner commands
  output logic seek_start_o,
  output logic [CYL_W-1:0] seek_cyl_o,
  output logic return_to_track_zero_cmd_o,
  output logic diag_start_o
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pins_f;
  logic sel;
  logic tag1;
  logic tag2;
  logic tag3;
  logic tag4;
  logic tag5;
  logic tag6;
  logic [BUS_OUT_W-1:0] bus;

  assign pins = {select_i, tag1_i, tag2_i, tag3_i, tag4_i, tag5_i, tag6_i, bus_out_i};

  pin_filter #(.W(PIN_W)) u_pins (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .pin_i(pins),
    .level_o(pins_f)
  );

  assign {sel, tag1, tag2, tag3, tag4, tag5, tag6, bus} = pins_f;

  // ------------------------------------------------------------
  // Seek watchdog
  // ------------------------------------------------------------
  drive_state_type q_ff;
  drive_state_type nxt_q;
  logic timeout;

  seek_timer #(.LIMIT(SEEK_LIMIT_CYCLES)) u_timer (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .run_i(q_ff.st == SEEK_BUSY),
    .expired_o(timeout)
  );

  // ------------------------------------------------------------
  // Decoded events
  // ------------------------------------------------------------
  logic tag1_rise;
  logic rtz_rise;
  logic tag5_rise;
  logic [CYL_W-1:0] addr;
  logic [CYL_W-1:0] limit;
  logic illegal;
  logic err_set;
  logic any_fault;
  logic [BUS_IN_W-1:0] status_word;
  logic [BUS_IN_W-1:0] maint_word;

  // Selection gates every tag; a deselected drive sees no edges at all
  assign tag1_rise = sel && tag1 && !q_ff.tag1_d; // [RULE1]
  assign rtz_rise = sel && tag3 && bus[RTZ_LINE] && !q_ff.rtz_d;
  assign tag5_rise = sel && tag5 && !q_ff.tag5_d;
  assign any_fault = |fault_bits_i; // [RULE13]

  // Cylinder address: low ten lines, then bit 10/11 from whichever extension is built
  always_comb begin
    addr = '0;
    addr[LOW_CYL_W-1:0] = bus[LOW_CYL_W-1:0]; // [RULE3]
    if (LOW_TAG_EXT) begin
      addr[CYL_BIT10] = tag4; // [RULE4]
    end else if (HEAD_TAG_EXT) begin
      addr[CYL_BIT10] = q_ff.hi_cyl[0]; // [RULE7]
      addr[CYL_BIT11] = q_ff.hi_cyl[1];
    end
  end

  // An unextended drive can only name cylinders up to its fixed limit
  assign limit = (LOW_TAG_EXT || HEAD_TAG_EXT) ? MAX_CYL : MAX_CYL_UNEXT;
  assign illegal = addr > limit;

  // Seek error sources; a set in the clearing cycle wins over the clear
  assign err_set = (tag1_rise && q_ff.st == SEEK_IDLE && illegal) // [RULE5]
                 || (q_ff.st == SEEK_BUSY && timeout) // [RULE10]
                 || off_recording_i; // [RULE11]

  // Status word: ready, on cylinder, seek error, fault
  always_comb begin
    status_word = '0;
    status_word[ST_READY] = q_ff.ready;
    status_word[ST_ON_TRACK] = q_ff.on_cyl;
    status_word[ST_SEEK_ERR] = q_ff.seek_err;
    status_word[ST_FAULT] = any_fault; // [RULE13]
  end

  // Maintenance reply picked by bus-out 1:0; bit 7 is valid, or busy for the test
  always_comb begin
    maint_word = '0;
    unique case (bus[1:0])
      REQ_FAULT: begin
        maint_word[FAULT_W-1:0] = fault_bits_i;
        maint_word[MAINT_FLAG] = 1'b1;
      end
      REQ_OPER: begin
        maint_word[FAULT_W-1:0] = oper_status_i;
        maint_word[MAINT_FLAG] = 1'b1;
      end
      REQ_UNIT: begin
        maint_word[FAULT_W-1:0] = unit_code_i;
        maint_word[MAINT_FLAG] = 1'b1;
      end
      REQ_DIAG: begin
        maint_word[MAINT_FLAG] = diag_busy_i; // [RULE14]
      end
    endcase
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.seek_start = 1'b0;
    nxt_q.return_to_track_zero_cmd = 1'b0;
    nxt_q.diag = 1'b0;
    nxt_q.tag1_d = sel && tag1;
    nxt_q.rtz_d = sel && tag3 && bus[RTZ_LINE];
    nxt_q.tag5_d = sel && tag5;
    // High cylinder bits are held until the next head tag
    if (HEAD_TAG_EXT && sel && tag2) begin
      nxt_q.hi_cyl = {bus[HI_CYL_BIT11_LINE], bus[HI_CYL_BIT10_LINE]}; // [RULE7]
    end
    unique case (q_ff.st)
      SEEK_IDLE: begin
        // A new cylinder tag while moving is ignored; the positioner finishes first
        if (tag1_rise && !illegal) begin
          nxt_q.cyl = addr;
          nxt_q.seek_start = 1'b1; // [RULE2]
          nxt_q.st = SEEK_BUSY;
        end else if (rtz_rise) begin
          nxt_q.cyl = '0;
          nxt_q.return_to_track_zero_cmd = 1'b1;
          nxt_q.st = SEEK_BUSY;
        end
      end
      SEEK_BUSY: begin
        if (timeout) begin
          nxt_q.st = SEEK_IDLE;
        end else if (seek_done_i) begin
          nxt_q.st = SEEK_IDLE;
          if (!q_ff.seek_err) begin
            nxt_q.first_ok = 1'b1;
          end
        end
      end
    endcase
    // Seek error: any source sets it, return to track zero clears it, and a set wins
    nxt_q.seek_err = err_set || (q_ff.seek_err && !rtz_rise); // [RULE12]
    // Diagnostic start is a one-clock pulse on the maintenance tag's rising edge
    if (tag5_rise && bus[1:0] == REQ_DIAG) begin
      nxt_q.diag = 1'b1; // [RULE14]
    end
    // Ready and on cylinder lag their inputs by one clock so the cable sees clean levels
    nxt_q.ready = speed_ok_i && q_ff.first_ok && !any_fault; // [RULE8]
    nxt_q.on_cyl = on_track_i && (q_ff.st == SEEK_IDLE); // [RULE9]
    // Bus-in source by tag; deselected drives leave the lines low
    if (!sel) begin
      nxt_q.bus_in = '0;
    end else if (tag5) begin
      nxt_q.bus_in = maint_word; // [RULE14]
    end else if (tag4 && !LOW_TAG_EXT) begin
      nxt_q.bus_in = sector_count_i; // [RULE15]
    end else if (tag6 && !LOW_TAG_EXT) begin
      nxt_q.bus_in = device_type_i; // [RULE15]
    end else begin
      nxt_q.bus_in = status_word; // [RULE6]
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every output is a state register bit, so no cable line can glitch
  assign bus_in_o = q_ff.bus_in;
  assign seek_start_o = q_ff.seek_start;
  assign seek_cyl_o = q_ff.cyl;
  assign return_to_track_zero_cmd_o = q_ff.return_to_track_zero_cmd;
  assign diag_start_o = q_ff.diag;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // Selection and command decode
  sel_gate_a: assert property (!sel |=> !seek_start_o && !diag_start_o) // [RULE1]
    else $error("command taken while not selected");
  quiet_bus_a: assert property (!sel |=> bus_in_o == '0) // [RULE1]
    else $error("bus-in driven while not selected");
  seek_start_a: assert property (tag1_rise && q_ff.st == SEEK_IDLE && !illegal // [RULE2]
    |=> seek_start_o ##1 !seek_start_o)
    else $error("cylinder tag did not start one seek");

  // Cylinder address loading
  low_addr_a: assert property (seek_start_o |-> seek_cyl_o[LOW_CYL_W-1:0] == $past(bus[LOW_CYL_W-1:0])) // [RULE3]
    else $error("cylinder low bits not loaded from bus-out");
  bit10_load_a: assert property (seek_start_o && LOW_TAG_EXT |-> seek_cyl_o[CYL_BIT10] == $past(tag4)) // [RULE4]
    else $error("cylinder bit 10 not taken from sector tag line");
  hi_cyl_load_a: assert property (seek_start_o && HEAD_TAG_EXT && !LOW_TAG_EXT // [RULE7]
    |-> seek_cyl_o[CYL_BIT11:CYL_BIT10] == $past(q_ff.hi_cyl))
    else $error("high cylinder bits not taken from the head tag store");

  // Seek error sources and clearing
  illegal_cyl_a: assert property (tag1_rise && q_ff.st == SEEK_IDLE && illegal // [RULE5]
    |=> q_ff.seek_err && !seek_start_o)
    else $error("illegal cylinder did not raise seek error");
  timeout_err_a: assert property (q_ff.st == SEEK_BUSY && timeout // [RULE10]
    |=> q_ff.seek_err && q_ff.st == SEEK_IDLE)
    else $error("seek timeout not reported");
  off_field_a: assert property (off_recording_i |=> q_ff.seek_err) // [RULE11]
    else $error("leaving recording area not reported");
  rtz_clear_a: assert property (rtz_rise && !err_set |=> !q_ff.seek_err) // [RULE12]
    else $error("return to track zero did not clear seek error");
  rtz_pulse_a: assert property (rtz_rise && q_ff.st == SEEK_IDLE && !tag1_rise // [RULE12]
    |=> return_to_track_zero_cmd_o)
    else $error("return to track zero not passed to the positioner");

  // Status word on the bus-in lines
  status_out_a: assert property (sel && tag1 && !tag4 && !tag5 && !tag6 // [RULE6]
    |=> bus_in_o[ST_SEEK_ERR] == $past(q_ff.seek_err))
    else $error("status word not driven under cylinder tag");
  ready_cause_a: assert property (q_ff.ready // [RULE8]
    |-> $past(speed_ok_i) && !$past(any_fault) && $past(q_ff.first_ok))
    else $error("ready without its conditions");
  on_track_a: assert property (!on_track_i |=> !q_ff.on_cyl) // [RULE9]
    else $error("on cylinder held while off track");
  fault_line_a: assert property (sel && !tag4 && !tag5 && !tag6 |=> bus_in_o[ST_FAULT] == $past(any_fault)) // [RULE13]
    else $error("fault line does not follow fault sources");

  // Maintenance, sector and device type replies
  maint_flag_a: assert property (sel && tag5 && bus[1:0] == REQ_DIAG // [RULE14]
    |=> bus_in_o[MAINT_FLAG] == $past(diag_busy_i))
    else $error("diagnostic busy flag wrong");
  sector_a: assert property (sel && tag4 && !tag5 && !LOW_TAG_EXT |=> bus_in_o == $past(sector_count_i)) // [RULE15]
    else $error("sector count not returned");
  dev_type_a: assert property (sel && tag6 && !tag4 && !tag5 && !LOW_TAG_EXT // [RULE15]
    |=> bus_in_o == $past(device_type_i))
    else $error("device type not returned");

  // Main scenarios
  seek_ok_c: cover property (seek_start_o ##[1:20] q_ff.st == SEEK_IDLE && q_ff.first_ok);
  rtz_c: cover property (q_ff.seek_err ##1 rtz_rise ##1 !q_ff.seek_err);
  diag_c: cover property (diag_start_o);
  hi_cyl_c: cover property (seek_start_o && HEAD_TAG_EXT && seek_cyl_o[CYL_BIT10]);
  timeout_c: cover property (q_ff.st == SEEK_BUSY && timeout);

endmodule

// [ctrl_model.sv]
// Behavioural disc controller that drives the tag and bus-out cable lines
`timescale 1ns/100ps
module ctrl_model
  import disc_tag_pkg::*;
(
  // Clock and returned bus-in
  input wire logic mclk_i,
  input wire logic [BUS_IN_W-1:0] bus_in_i,
  // Cable lines towards the drive
  output logic select_o,
  output logic [5:0] tag_o,
  output logic [BUS_OUT_W-1:0] bus_out_o
);
  // ----------------------------------------
  // Idle cable
  // ----------------------------------------
  initial begin
    select_o = 1'b0;
    tag_o = 6'h00;
    bus_out_o = 11'h000;
  end

  // Selection stays put between commands so the tag receivers remain enabled
  task automatic set_select(input logic val);
    @(negedge mclk_i);
    select_o = val;
  endtask

  // One tag cycle; tag cycles never overlap, so a high-cylinder tag
  // would always be complete before a cylinder-select tag
  task automatic issue(input logic [5:0] tags, input logic [BUS_OUT_W-1:0] bus,
                       output logic [BUS_IN_W-1:0] seen);
    @(negedge mclk_i);
    tag_o = tags;
    bus_out_o = bus;
    // Bus-in is read while the tag is still held, after the filter latency
    repeat (5) @(negedge mclk_i);
    seen = bus_in_i;
    @(negedge mclk_i);
    tag_o = 6'h00;
    // Released lines must not keep showing the old value
    bus_out_o = ~bus;
    repeat (5) @(negedge mclk_i);
  endtask
endmodule

// [disc_tag_bus_seek_status_port_bench.sv]
// Self-checking bench for the drive-side tag decoder
`timescale 1ns/100ps
module disc_tag_bus_seek_status_port_bench;
  import disc_tag_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic select_w;
  logic [5:0] tag_w;
  logic [BUS_OUT_W-1:0] bus_out_w;
  logic speed_ok_i = 1'b0;
  logic on_track_i = 1'b0;
  logic off_recording_i = 1'b0;
  logic seek_done_i = 1'b0;
  logic [FAULT_W-1:0] fault_bits_i = 7'h00;
  logic [FAULT_W-1:0] oper_status_i = 7'h2A;
  logic [FAULT_W-1:0] unit_code_i = 7'h13;
  logic diag_busy_i = 1'b1;
  logic [BUS_IN_W-1:0] bus_in_o;
  logic seek_start_o;
  logic [CYL_W-1:0] seek_cyl_o;
  logic return_to_track_zero_cmd_o;
  logic diag_start_o;
  logic select2_w;
  logic [5:0] tag2_w;
  logic [BUS_OUT_W-1:0] bus_out2_w;
  logic [BUS_IN_W-1:0] bus_in2;
  logic [CYL_W-1:0] head_cyl;
  logic [BUS_IN_W-1:0] seen;
  logic [BUS_IN_W-1:0] exp_m [4];
  logic [CYL_W-1:0] last_cyl = 12'h000;
  int fails = 0;
  int checked = 0;
  int starts = 0;
  int rtzs = 0;
  int diags = 0;
  int cycles = 0;

  // 25 MHz clock
  always #20 mclk_i = ~mclk_i;

  // ----------------------------------------
  // Design and controller model
  // ----------------------------------------
  disc_tag_bus_seek_status_port #(.LOW_TAG_EXT(1'b1), .SEEK_LIMIT_CYCLES(50)) dut_u (
    .mclk_i(mclk_i), .reset_i(reset_i), .select_i(select_w),
    .tag1_i(tag_w[0]), .tag2_i(tag_w[1]), .tag3_i(tag_w[2]),
    .tag4_i(tag_w[3]), .tag5_i(tag_w[4]), .tag6_i(tag_w[5]), .bus_out_i(bus_out_w),
    .speed_ok_i(speed_ok_i), .on_track_i(on_track_i), .off_recording_i(off_recording_i),
    .seek_done_i(seek_done_i), .fault_bits_i(fault_bits_i), .oper_status_i(oper_status_i),
    .unit_code_i(unit_code_i), .diag_busy_i(diag_busy_i), .sector_count_i(8'h5C),
    .device_type_i(8'hE1), .bus_in_o(bus_in_o), .seek_start_o(seek_start_o),
    .seek_cyl_o(seek_cyl_o), .return_to_track_zero_cmd_o(return_to_track_zero_cmd_o),
    .diag_start_o(diag_start_o));

  ctrl_model ctrl_u (.mclk_i(mclk_i), .bus_in_i(bus_in_o), .select_o(select_w),
    .tag_o(tag_w), .bus_out_o(bus_out_w));

  // Second drive: head-tag extension and the smaller cylinder limit, on its own cable
  disc_tag_bus_seek_status_port #(.HEAD_TAG_EXT(1'b1), .MAX_CYL(MAX_CYL_SMALL), .SEEK_LIMIT_CYCLES(50)) head_u (
    .mclk_i(mclk_i), .reset_i(reset_i), .select_i(select2_w),
    .tag1_i(tag2_w[0]), .tag2_i(tag2_w[1]), .tag3_i(tag2_w[2]),
    .tag4_i(tag2_w[3]), .tag5_i(tag2_w[4]), .tag6_i(tag2_w[5]), .bus_out_i(bus_out2_w),
    .speed_ok_i(speed_ok_i), .on_track_i(on_track_i), .off_recording_i(off_recording_i),
    .seek_done_i(seek_done_i), .fault_bits_i(fault_bits_i), .oper_status_i(oper_status_i),
    .unit_code_i(unit_code_i), .diag_busy_i(diag_busy_i), .sector_count_i(8'h5C),
    .device_type_i(8'hE1), .bus_in_o(bus_in2), .seek_start_o(), .seek_cyl_o(head_cyl),
    .return_to_track_zero_cmd_o(), .diag_start_o());

  ctrl_model ctrl2_u (.mclk_i(mclk_i), .bus_in_i(bus_in2), .select_o(select2_w),
    .tag_o(tag2_w), .bus_out_o(bus_out2_w));

  // Pulse counters; a missed or doubled pulse shows up in the counts
  always @(posedge mclk_i) begin
    if (seek_start_o === 1'b1) begin
      starts++;
      last_cyl = seek_cyl_o;
    end
    if (return_to_track_zero_cmd_o === 1'b1) rtzs++;
    if (diag_start_o === 1'b1) diags++;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Counts: %0d checked, %0d fails", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Ceiling well above the roughly 470 cycles the tests need
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      conclude();
    end
  end

  // Servo side: report the seek finished and the heads on track
  task automatic finish_seek();
    @(negedge mclk_i);
    seek_done_i = 1'b1;
    on_track_i = 1'b1;
    @(negedge mclk_i);
    seek_done_i = 1'b0;
    repeat (3) @(negedge mclk_i);
  endtask

  // Status word through the device-type tag, which the low-tag option turns off
  task automatic read_status();
    ctrl_u.issue(6'h20, 11'h000, seen);
  endtask

  // Return to track zero, then let the positioner settle
  task automatic return_to_track_zero_cmd();
    ctrl_u.issue(6'h04, 11'h040, seen);
    finish_seek();
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge mclk_i);
    reset_i = 1'b0;
    check(12'(bus_in_o), 12'h000, "bus-in after reset");
    // Head-tag extension: the high cylinder bit comes from the earlier head tag
    ctrl2_u.set_select(1'b1);
    ctrl2_u.issue(6'h02, 11'h080, seen);
    ctrl2_u.issue(6'h01, 11'h164, seen);
    check(head_cyl, 12'h564, "head-tag top cylinder");
    finish_seek();
    // Cylinder 1381 is beyond the smaller limit
    ctrl2_u.issue(6'h01, 11'h165, seen);
    check(head_cyl, 12'h564, "smaller limit seek started");
    ctrl2_u.issue(6'h04, 11'h000, seen);
    check(12'(seen), 12'h006, "smaller limit status");
    ctrl2_u.issue(6'h08, 11'h000, seen);
    check(12'(seen), 12'h05C, "sector count");
    ctrl2_u.issue(6'h20, 11'h000, seen);
    check(12'(seen), 12'h0E1, "device type");
    on_track_i = 1'b0;
    $display("test head extension done");
    // Unselected drive ignores tags and keeps bus-in quiet
    ctrl_u.issue(6'h01, 11'h005, seen);
    check(12'(seen), 12'h000, "unselected bus-in");
    check(12'(starts), 12'h000, "unselected seek");
    $display("test unselected done");
    ctrl_u.set_select(1'b1);
    speed_ok_i = 1'b1;
    // Ten-bit cylinder load and seek start
    ctrl_u.issue(6'h01, 11'h2A5, seen);
    check(12'(starts), 12'h001, "seek count");
    check(last_cyl, 12'h2A5, "low cylinder");
    check(12'(seen[ST_SEEK_ERR]), 12'h000, "status during tag");
    finish_seek();
    read_status();
    check(12'(seen), 12'h003, "ready and on cylinder");
    $display("test low cylinder done");
    // Bit 10 on the current-sector line; highest legal cylinder 1634
    ctrl_u.issue(6'h09, 11'h262, seen);
    check(last_cyl, 12'h662, "top cylinder");
    check(12'(seen), 12'h003, "status under cylinder tag");
    finish_seek();
    // Cylinder 1635 is refused with seek error
    ctrl_u.issue(6'h09, 11'h263, seen);
    check(12'(starts), 12'h002, "illegal seek started");
    read_status();
    check(12'(seen), 12'h007, "illegal seek status");
    return_to_track_zero_cmd();
    check(12'(rtzs), 12'h001, "rtz pulse");
    read_status();
    check(12'(seen), 12'h003, "error cleared");
    $display("test cylinder limits done");
    // A seek with no completion times out
    ctrl_u.issue(6'h01, 11'h005, seen);
    repeat (60) @(negedge mclk_i);
    read_status();
    check(12'(seen[ST_SEEK_ERR]), 12'h001, "timeout error");
    return_to_track_zero_cmd();
    // Leaving the recording area
    @(negedge mclk_i);
    off_recording_i = 1'b1;
    @(negedge mclk_i);
    off_recording_i = 1'b0;
    read_status();
    check(12'(seen[ST_SEEK_ERR]), 12'h001, "off recording error");
    return_to_track_zero_cmd();
    // Drift off cylinder
    on_track_i = 1'b0;
    read_status();
    check(12'(seen), 12'h001, "off cylinder");
    on_track_i = 1'b1;
    $display("test seek errors done");
    // Each fault source alone raises fault and drops ready
    for (int i = 0; i < FAULT_W; i++) begin
      fault_bits_i = 7'(1 << i);
      read_status();
      check(12'(seen), 12'h00A, "fault source");
    end
    $display("test faults done");
    // Maintenance requests, every code
    fault_bits_i = 7'h55;
    exp_m[0] = {1'b1, 7'h55};
    exp_m[1] = {1'b1, oper_status_i};
    exp_m[2] = {1'b1, unit_code_i};
    exp_m[3] = {diag_busy_i, 7'h00};
    for (int k = 0; k < 4; k++) begin
      ctrl_u.issue(6'h10, {9'h000, 2'(k)}, seen);
      check(12'(seen), 12'(exp_m[k]), "maintenance reply");
    end
    check(12'(diags), 12'h001, "diagnostic start");
    $display("test maintenance done");
    conclude();
  end
endmodule
